// ==== hdl/sfrs_pkg.sv ====
// Purpose: Shared constants and types of the fundamental reset sequencer
// Assumes: 250 MHz system clock
// Notes:   Register map is word aligned, byte addressed
package sfrs_pkg;

  localparam int          CLK_KHZ        = 250000;
  localparam int          REL_MS         = 20;
  localparam int          QUASI_MS       = 100;
  localparam int          REL_CYCLES     = REL_MS * CLK_KHZ;
  localparam int          QUASI_CYCLES   = QUASI_MS * CLK_KHZ;
  localparam int          MSMB_KHZ       = 100;
  localparam int          MSMB_DIV       = CLK_KHZ / MSMB_KHZ;

  localparam logic [7:0]  OFS_SWITCH_CTL = 8'h00;
  localparam logic [7:0]  OFS_SMBSTS     = 8'h04;
  localparam logic [7:0]  OFS_BOOTSTS    = 8'h08;
  localparam logic [7:0]  OFS_SEQSTS     = 8'h0C;
  localparam logic [7:0]  OFS_PHY_BASE   = 8'h40;

  localparam int          CTL_UNLOCK_BIT = 0;
  localparam int          CTL_HALT_BIT   = 1;
  localparam int          STS_DONE_BIT   = 0;
  localparam int          STS_ERR_BIT    = 1;
  localparam int          STS_CODE_LSB   = 8;
  localparam int          PHY_RETRAIN    = 0;

  localparam logic [7:0]  PHY_RESET      = 8'h00;
  localparam logic [15:0] TEST_MODE_MASK = 16'hF000;
  localparam logic [15:0] EE_MODE_MASK   = 16'h00FF;

  typedef struct packed {
    logic [3:0] mode;
    logic       halt;
    logic [1:0] slv_addr;
    logic [1:0] clk_mode;
  } sfrs_strap_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } sfrs_ee_wr_t;

  typedef enum logic [3:0] {
    ST_RESET,
    ST_STRAP,
    ST_TEST,
    ST_INIT,
    ST_UNLOCK,
    ST_PLL,
    ST_EEPROM,
    ST_HALT,
    ST_LOCK,
    ST_NORMAL
  } sfrs_state_t;

endpackage : sfrs_pkg

// ==== hdl/sfrs_seq.sv ====
// Purpose: Fundamental reset sequencer of a multi-port switch
// Assumes: global_reset_n, straps and pll lock are asynchronous pins
// Notes:   Registers on Avalon-MM; EEPROM reader is an outside engine
// Contract
// - Cold or warm fundamental reset starts on global reset assertion.
// - Sequence holds until the global reset input has cleared.
// - Boot straps are captured on the global reset deasserting edge.
// - Test operating mode skips normal steps for the test sequence.
// - In normal modes all registers load their defaults.
// - Register unlock bit is set after register initialization.
// - PLL is initialized, lock awaited, clock recovery held reset.
// - Stack reset released and training begun within 20 ms.
// - All stacks in quasi-reset within 100 ms of reset clearing.
// - Quasi-reset stacks answer configuration requests with retry status.
// - Quasi-reset stacks discard other TLPs but return credits.
// - Master SMBus runs at 100 kHz during the sequence.
// - Slave SMBus released with address bits from straps.
// - EEPROM capable modes load EEPROM contents into registers.
// - EEPROM write of full retrain bit retrains that port immediately.
// - EEPROM error aborts load, sets halt, records error details.
// - EEPROM done flag set on completion or error.
// - While halt bit set stacks stay quasi-reset, rest runs.
// - Unlock bit cleared once halt bit is clear.
// - Normal operation then begins per captured operating mode.
// - Halt strap holds device in reset with both SMBuses active.
// - Straps are ignored outside a fundamental reset.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
module sfrs_seq
  import sfrs_pkg::*;
#(
  parameter int NPORTS       = 12,
  parameter int REL_COUNT    = sfrs_pkg::REL_CYCLES,
  parameter int QUASI_COUNT  = sfrs_pkg::QUASI_CYCLES
)(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic                 global_reset_n,
  input  wire sfrs_pkg::sfrs_strap_t strap_pins,
  input  wire logic                 pll_lock,
  output logic                      pll_init,
  output logic                      cdr_reset,
  output logic                      stack_reset_n,
  output logic                      stack_quasi,
  output logic                      cfg_retry_en,
  output logic                      tlp_discard_en,
  output logic                      normal_op,
  output logic [3:0]                switch_operating_mode,
  output logic                      test_seq_req,
  output logic                      msmb_en,
  output logic                      msmb_tick,
  output logic                      slv_smb_en,
  output logic [1:0]                slave_smbus_address_straps,
  output logic                      ee_load_req,
  input  wire logic                 ee_wr_valid,
  input  wire sfrs_pkg::sfrs_ee_wr_t ee_wr,
  input  wire logic                 ee_done,
  input  wire logic                 ee_error,
  input  wire logic [3:0]           ee_err_code,
  output logic [NPORTS-1:0]         retrain_pulse,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest
);
  import sfrs_pkg::*;

  localparam int TW = 25;
  localparam int DW = 12;

  sfrs_state_t     state_reg;
  sfrs_state_t     state_next;
  logic            glob_meta_reg;
  logic            glob_sync_reg;
  logic            glob_prev_reg;
  logic            lock_meta_reg;
  logic            lock_sync_reg;
  sfrs_strap_t     strap_meta_reg;
  sfrs_strap_t     strap_sync_reg;
  sfrs_strap_t     strap_reg;
  logic [TW-1:0]   timer_reg;
  logic [DW-1:0]   div_reg;
  logic            rel_reg;
  logic            unlock_reg;
  logic            halt_reg;
  logic            done_reg;
  logic            err_reg;
  logic [3:0]      code_reg;
  logic [7:0]      phy_reg [NPORTS];
  logic            ack_reg;
  logic            rst_edge;
  logic            ee_take;
  logic            ee_err_ev;
  logic            bus_req;
  logic            bus_wr;
  logic            ctl_wr;
  logic [7:0]      wr_addr;
  logic [7:0]      wr_data;
  logic            wr_any;
  logic            bus_done;

  function automatic logic is_phy(input logic [7:0] a, input int p);
    is_phy = (a == 8'(OFS_PHY_BASE + 4 * p));
  endfunction : is_phy

  // Pins pass two flops before use
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      glob_meta_reg  <= 1'b0;
      glob_sync_reg  <= 1'b0;
      glob_prev_reg  <= 1'b0;
      lock_meta_reg  <= 1'b0;
      lock_sync_reg  <= 1'b0;
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
    end
    else
    begin
      glob_meta_reg  <= global_reset_n;
      glob_sync_reg  <= glob_meta_reg;
      glob_prev_reg  <= glob_sync_reg;
      lock_meta_reg  <= pll_lock;
      lock_sync_reg  <= lock_meta_reg;
      strap_meta_reg <= strap_pins;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  assign rst_edge = glob_sync_reg & ~glob_prev_reg;

  // straps only sampled at that edge
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      strap_reg <= '0;
    else if (rst_edge)
      strap_reg <= strap_sync_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= ST_RESET;
    else if (!glob_sync_reg)
      state_reg <= ST_RESET;
    else
      state_reg <= state_next;
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET:  if (rst_edge) state_next = ST_STRAP;
      ST_STRAP:  state_next = TEST_MODE_MASK[strap_reg.mode] ? ST_TEST : ST_INIT;
      ST_TEST:   state_next = ST_TEST;
      ST_INIT:   state_next = ST_UNLOCK;
      ST_UNLOCK: state_next = ST_PLL;
      ST_PLL:    if (lock_sync_reg)
                   state_next = EE_MODE_MASK[strap_reg.mode] ? ST_EEPROM : ST_HALT;
      ST_EEPROM: if (ee_done || ee_error) state_next = ST_HALT;
      ST_HALT:   if (!halt_reg) state_next = ST_LOCK;
      ST_LOCK:   state_next = ST_NORMAL;
      ST_NORMAL: state_next = ST_NORMAL;
      default:   state_next = ST_RESET;
    endcase
  end

  // Time since reset cleared, saturating
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      timer_reg <= '0;
    else if (state_reg == ST_RESET)
      timer_reg <= '0;
    else if (timer_reg != '1)
      timer_reg <= timer_reg + 1'b1;
  end

  // deadline keeps quasi-reset well inside 100 ms
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rel_reg <= 1'b0;
    else if (state_reg == ST_RESET || state_reg == ST_TEST)
      rel_reg <= 1'b0;
    else if (state_reg == ST_PLL && lock_sync_reg)
      rel_reg <= 1'b1;
    // Sync and edge detect use three cycles of the deadline before the timer runs
    else if (state_reg != ST_STRAP && timer_reg >= TW'(REL_COUNT - 4))
      rel_reg <= 1'b1;
  end

  assign stack_reset_n = rel_reg;
  assign stack_quasi   = rel_reg & (state_reg != ST_NORMAL);
  assign cfg_retry_en   = stack_quasi;
  assign tlp_discard_en = stack_quasi;
  assign normal_op      = (state_reg == ST_NORMAL);
  assign switch_operating_mode = strap_reg.mode;
  assign test_seq_req   = (state_reg == ST_TEST);
  assign pll_init       = (state_reg == ST_PLL);
  assign cdr_reset      = (state_reg == ST_PLL) & ~lock_sync_reg;
  assign msmb_en    = (state_reg != ST_RESET) & (state_reg != ST_TEST);
  assign slv_smb_en = msmb_en;
  assign slave_smbus_address_straps = strap_reg.slv_addr;
  assign ee_load_req = (state_reg == ST_EEPROM);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      div_reg <= '0;
    else if (!msmb_en || div_reg == DW'(MSMB_DIV - 1))
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end

  assign msmb_tick = msmb_en & (div_reg == DW'(MSMB_DIV - 1));

  // Bus write stalls behind an EEPROM write so neither is lost
  assign bus_req         = avs_read | avs_write;
  assign ee_take         = ee_wr_valid & (state_reg == ST_EEPROM);
  assign bus_done        = ack_reg & ~ee_take;
  assign avs_waitrequest = bus_req & ~bus_done;
  assign bus_wr          = avs_write & bus_done;
  assign wr_any          = ee_take | bus_wr;
  assign wr_addr         = ee_take ? ee_wr.addr : avs_address;
  assign wr_data         = ee_take ? ee_wr.data : avs_writedata[7:0];
  assign ctl_wr          = wr_any & (wr_addr == OFS_SWITCH_CTL);
  assign ee_err_ev       = (state_reg == ST_EEPROM) & ee_error;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ack_reg <= 1'b0;
    else
      ack_reg <= bus_req & ~bus_done;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      unlock_reg <= 1'b0;
    else if (state_reg == ST_RESET || state_reg == ST_INIT)
      unlock_reg <= 1'b0;
    else if (state_reg == ST_UNLOCK)
      unlock_reg <= 1'b1;
    else if (state_reg == ST_LOCK)
      unlock_reg <= 1'b0;
  end

  // error sets halt, wins over a clear
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      halt_reg <= 1'b0;
    else if (state_reg == ST_RESET || state_reg == ST_INIT)
      halt_reg <= 1'b0;
    else if (state_reg == ST_UNLOCK)
      halt_reg <= strap_reg.halt;
    else if (ee_err_ev)
      halt_reg <= 1'b1;
    else if (ctl_wr)
      halt_reg <= wr_data[CTL_HALT_BIT];
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      done_reg <= 1'b0;
      err_reg  <= 1'b0;
      code_reg <= '0;
    end
    else if (state_reg == ST_RESET || state_reg == ST_INIT)
    begin
      done_reg <= 1'b0;
      err_reg  <= 1'b0;
      code_reg <= '0;
    end
    else if (state_reg == ST_EEPROM && (ee_done || ee_error))
    begin
      done_reg <= 1'b1;
      err_reg  <= ee_error;
      code_reg <= ee_error ? ee_err_code : 4'h0;
    end
  end

  // Link state registers, writable only while unlocked; retrain bit 0 not stored
  generate
    for (genvar p = 0; p < NPORTS; p++)
    begin : g_phy
      logic hit;
      assign hit = wr_any & is_phy(wr_addr, p);
      always_ff @(posedge clk_sys or negedge rst_b)
      begin
        if (!rst_b)
          phy_reg[p] <= PHY_RESET;
        else if (state_reg == ST_RESET || state_reg == ST_INIT)
          phy_reg[p] <= PHY_RESET;
        else if (hit && unlock_reg)
          phy_reg[p] <= {wr_data[7:1], 1'b0};
      end
      always_ff @(posedge clk_sys or negedge rst_b)
      begin
        if (!rst_b)
          retrain_pulse[p] <= 1'b0;
        else
          retrain_pulse[p] <= hit & ee_take & wr_data[PHY_RETRAIN];
      end
      a_retrain_now: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ee_take && is_phy(ee_wr.addr, p) && ee_wr.data[PHY_RETRAIN]) |=> retrain_pulse[p])
        else $error("retrain pulse missing");
      a_retrain_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
        retrain_pulse[p]
        |-> $past(ee_take && is_phy(ee_wr.addr, p) && ee_wr.data[PHY_RETRAIN]))
        else $error("retrain pulse without eeprom write");
    end
  endgenerate

  // Read data loaded one edge early so it stands at the ack edge
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      avs_readdata <= '0;
    else if (avs_read && !ack_reg)
    begin
      avs_readdata <= '0;
      case (avs_address)
        OFS_SWITCH_CTL: avs_readdata <= {30'h0, halt_reg, unlock_reg};
        OFS_SMBSTS:  avs_readdata <= {20'h0, code_reg, 6'h0, err_reg, done_reg};
        OFS_BOOTSTS: avs_readdata <= {23'h0, strap_reg};
        OFS_SEQSTS:  avs_readdata <= {26'h0, rel_reg, stack_quasi, 4'(state_reg)};
        default:
          for (int p = 0; p < NPORTS; p++)
            if (is_phy(avs_address, p))
              avs_readdata <= {24'h0, phy_reg[p]};
      endcase
    end
  end

  // Checks
  a_hold_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !glob_sync_reg |=> state_reg == ST_RESET)
    else $error("left reset while global reset held");

  a_strap_take: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rst_edge |=> strap_reg == $past(strap_sync_reg))
    else $error("straps not captured at release");

  a_strap_ignore: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !rst_edge |=> $stable(strap_reg))
    else $error("straps changed outside reset release");

  a_test_path: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == ST_STRAP && TEST_MODE_MASK[strap_reg.mode] && glob_sync_reg)
    |=> test_seq_req && !stack_reset_n)
    else $error("test mode did not take test path");

  a_unlock_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == ST_UNLOCK && glob_sync_reg) |=> unlock_reg)
    else $error("unlock bit not set");

  a_stack_deadline: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (timer_reg == TW'(REL_COUNT) && state_reg != ST_TEST && glob_sync_reg)
    |-> stack_reset_n)
    else $error("stack reset held past deadline");

  a_quasi_deadline: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (timer_reg == TW'(QUASI_COUNT) && state_reg != ST_TEST && glob_sync_reg)
    |-> stack_quasi || normal_op)
    else $error("stacks not in quasi-reset by deadline");

  a_quasi_retry: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == ST_HALT && rel_reg) |-> cfg_retry_en && tlp_discard_en)
    else $error("halted stacks not in quasi-reset");

  a_ee_done: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == ST_EEPROM && (ee_done || ee_error) && glob_sync_reg)
    |=> done_reg && err_reg == $past(ee_error))
    else $error("eeprom done flag wrong");

  a_halt_error: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ee_err_ev && glob_sync_reg) |=> halt_reg && state_reg == ST_HALT)
    else $error("eeprom error did not halt");

  a_lock_after: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == ST_HALT && !halt_reg && glob_sync_reg)
    |=> ##1 !unlock_reg && normal_op)
    else $error("unlock not cleared after halt");

  a_msmb_rate: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (msmb_tick && msmb_en) |=> !msmb_tick)
    else $error("master bus tick too fast");

endmodule : sfrs_seq

// ==== tb/sfrs_ee_model.sv ====
// Purpose: Serial EEPROM loader model on the far side of the sequencer
// Assumes: Image is streamed only while ee_load_req is high
// Notes:   Idle data lines toggle so a stale value never looks valid
module sfrs_ee_model
  import sfrs_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             ee_load_req,
  input  wire logic             err_mode,
  input  wire logic             slow,
  output logic                  ee_wr_valid,
  output sfrs_pkg::sfrs_ee_wr_t ee_wr,
  output logic                  ee_done,
  output logic                  ee_error,
  output logic [3:0]            ee_err_code
);
  logic [7:0] step;
  logic [7:0] gap;
  logic [7:0] d;
  assign gap = slow ? 8'h28 : 8'h02;
  assign d   = step - gap;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      step        <= 8'h00;
      ee_wr_valid <= 1'b0;
      ee_wr       <= '0;
      ee_done     <= 1'b0;
      ee_error    <= 1'b0;
      ee_err_code <= 4'h0;
    end
    else
    begin
      step        <= ee_load_req ? step + 8'h01 : 8'h00;
      ee_wr_valid <= 1'b0;
      ee_wr       <= ~ee_wr;
      ee_done     <= 1'b0;
      ee_error    <= 1'b0;
      // Three phy writes, ports 1 and 3 ask for retrain; an error cuts it after one
      if (ee_load_req && step >= gap && d < 8'h03 && !(err_mode && d != 8'h00))
      begin
        ee_wr_valid <= 1'b1;
        ee_wr       <= '{addr: 8'h44 + {d[5:0], 2'b00}, data: {7'h00, ~d[0]}};
      end
      if (ee_load_req && d == 8'h03 && !err_mode)
        ee_done <= 1'b1;
      if (ee_load_req && d == 8'h01 && err_mode)
      begin
        ee_error    <= 1'b1;
        ee_err_code <= 4'h5;
      end
    end
  end
endmodule : sfrs_ee_model

// ==== tb/sfrs_seq_tb_top.sv ====
// Purpose: Self-checking bench of the fundamental reset sequencer
// Assumes: Short release count so the run stays brief
// Notes:   Bench plays the external SMBus master through the register bus
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module sfrs_seq_tb_top
  import sfrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REL = 200;
  logic        clk_sys, rst_b, global_reset_n, pll_lock, err_mode, slow, lock_en, clr;
  logic        pll_init, cdr_reset, stack_reset_n, stack_quasi, cfg_retry_en;
  logic        tlp_discard_en, normal_op, test_seq_req, msmb_en, msmb_tick, slv_smb_en;
  logic        ee_load_req, ee_wr_valid, ee_done, ee_error, ee_seen;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [1:0]  slave_smbus_address_straps;
  logic [3:0]  switch_operating_mode, ee_err_code, pll_cnt;
  logic [7:0]  avs_address;
  logic [11:0] retrain_pulse, rt_seen;
  logic [31:0] avs_writedata, avs_readdata, rd;
  sfrs_strap_t strap_pins, s;
  sfrs_ee_wr_t ee_wr;
  int          n_errors  = 0;
  int          cmp_count = 0;
  int          k;

  sfrs_seq #(.NPORTS(12), .REL_COUNT(REL), .QUASI_COUNT(2 * REL)) u_dut (
    .clk_sys, .rst_b, .global_reset_n, .strap_pins, .pll_lock, .pll_init, .cdr_reset,
    .stack_reset_n, .stack_quasi, .cfg_retry_en, .tlp_discard_en, .normal_op,
    .switch_operating_mode, .test_seq_req, .msmb_en, .msmb_tick, .slv_smb_en,
    .slave_smbus_address_straps, .ee_load_req, .ee_wr_valid, .ee_wr, .ee_done,
    .ee_error, .ee_err_code, .retrain_pulse, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);

  sfrs_ee_model u_ee (.clk_sys, .rst_b, .ee_load_req, .err_mode, .slow, .ee_wr_valid,
    .ee_wr, .ee_done, .ee_error, .ee_err_code);

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // PLL locks some cycles after init; lock is lost with the global reset
  always @(posedge clk_sys)
  begin
    pll_cnt <= !pll_init ? 4'h0 : pll_cnt + {3'b000, pll_cnt != 4'hF};
    pll_lock <= lock_en & global_reset_n & (pll_lock | pll_cnt >= 4'h8);
    rt_seen <= clr ? 12'h000 : rt_seen | retrain_pulse;
    ee_seen <= clr ? 1'b0 : ee_seen | ee_load_req;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // One Avalon transfer; request holds until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
    begin
      @(posedge clk_sys);
      w++;
    end
    while (avs_waitrequest !== 1'b0 && w < 200);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
    if (w >= 200)
      n_errors++;
  endtask : bus

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("register read", e, rd)
  endtask : chk_rd

  task automatic wait_normal();
    for (k = 0; k < 600 && normal_op !== 1'b1; k++)
      @(posedge clk_sys);
  endtask : wait_normal

  // Pulse the global reset, then count cycles until the stacks leave reset
  task automatic run_seq(input sfrs_strap_t st, input logic em);
    global_reset_n <= 1'b0;
    strap_pins     <= st;
    err_mode       <= em;
    clr            <= 1'b1;
    repeat (10) @(posedge clk_sys);
    `CHK("held in reset", 2'b00, {stack_reset_n, normal_op})
    global_reset_n <= 1'b1;
    clr            <= 1'b0;
    for (k = 0; k < REL + 100 && stack_reset_n !== 1'b1; k++)
    begin
      @(posedge clk_sys);
      if (k == 8)
        strap_pins <= ~st;
    end
  endtask : run_seq

  initial
  begin
    rst_b = 1'b0;
    global_reset_n = 1'b0;
    strap_pins = '0;
    err_mode = 1'b0;
    slow = 1'b1;
    lock_en = 1'b0;
    clr = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk_sys);
    `CHK("no progress", 2'b00, {stack_reset_n, msmb_en})
    // EEPROM mode with a PLL that stays unlocked: release is forced by time
    s = '{mode: 4'h0, halt: 1'b0, slv_addr: 2'h2, clk_mode: 2'h1};
    run_seq(s, 1'b0);
    `CHK("release time", 1'b1, k <= REL + 8)
    `CHK("quasi outputs", 3'b111, {stack_quasi, cfg_retry_en, tlp_discard_en})
    `CHK("pll step", 2'b11, {pll_init, cdr_reset})
    `CHK("slave address", s.slv_addr, slave_smbus_address_straps)
    `CHK("smbus enables", 2'b11, {msmb_en, slv_smb_en})
    chk_rd(OFS_SWITCH_CTL, 32'h1);
    chk_rd(OFS_BOOTSTS, {23'h0, s});
    lock_en <= 1'b1;
    wait_normal();
    `CHK("normal", 2'b10, {normal_op, stack_quasi})
    `CHK("mode", s.mode, switch_operating_mode)
    `CHK("retrain ports", 12'h00A, rt_seen)
    chk_rd(OFS_SWITCH_CTL, 32'h0);
    chk_rd(OFS_SMBSTS, 32'h1);
    // EEPROM error after the first write: load aborts and halts
    s = '{mode: 4'h1, halt: 1'b0, slv_addr: 2'h1, clk_mode: 2'h2};
    slow <= 1'b0;
    run_seq(s, 1'b1);
    for (k = 0; k < 300 && !(ee_seen && !ee_load_req); k++)
      @(posedge clk_sys);
    repeat (50) @(posedge clk_sys);
    chk_rd(OFS_SWITCH_CTL, 32'h3);
    chk_rd(OFS_SMBSTS, 32'h503);
    `CHK("halted", 3'b101, {stack_quasi, normal_op, msmb_en})
    `CHK("retrain before abort", 12'h002, rt_seen)
    bus(1'b1, OFS_SWITCH_CTL, 32'h0);
    wait_normal();
    `CHK("normal after clear", 1'b1, normal_op)
    // Halt strap in a mode without EEPROM
    s = '{mode: 4'h8, halt: 1'b1, slv_addr: 2'h0, clk_mode: 2'h3};
    run_seq(s, 1'b0);
    repeat (300) @(posedge clk_sys);
    `CHK("strap halt", 4'b0111, {normal_op, stack_quasi, msmb_en, slv_smb_en})
    `CHK("no eeprom load", 1'b0, ee_seen)
    chk_rd(OFS_SWITCH_CTL, 32'h3);
    for (k = 0; k < 3000 && msmb_tick !== 1'b1; k++)
      @(posedge clk_sys);
    @(posedge clk_sys);
    for (k = 1; k < 3000 && msmb_tick !== 1'b1; k++)
      @(posedge clk_sys);
    `CHK("tick period", MSMB_DIV, k)
    bus(1'b1, OFS_PHY_BASE + 8'h04, 32'hFF);
    chk_rd(OFS_PHY_BASE + 8'h04, 32'hFE);
    bus(1'b1, 8'h80, 32'h5A);
    chk_rd(8'h80, 32'h0);
    bus(1'b1, OFS_SWITCH_CTL, 32'h0);
    wait_normal();
    `CHK("normal after strap halt", 1'b1, normal_op)
    bus(1'b1, OFS_PHY_BASE + 8'h04, 32'h00);
    chk_rd(OFS_PHY_BASE + 8'h04, 32'hFE);
    // Warm reset brings the port 1 link register back to its default
    s = '{mode: 4'h8, halt: 1'b0, slv_addr: 2'h3, clk_mode: 2'h0};
    run_seq(s, 1'b0);
    wait_normal();
    chk_rd(OFS_PHY_BASE + 8'h04, 32'h0);
    // Test mode skips the normal steps
    s = '{mode: 4'hC, halt: 1'b0, slv_addr: 2'h1, clk_mode: 2'h1};
    run_seq(s, 1'b0);
    `CHK("test seq", 4'b1000, {test_seq_req, stack_reset_n, msmb_en, normal_op})
    `CHK("test mode", 4'hC, switch_operating_mode)
    tally_and_finish();
  end

  initial
  begin
    repeat (30000) @(posedge clk_sys);
    n_errors++;
    tally_and_finish();
  end
endmodule : sfrs_seq_tb_top
